// >>> logic/file_record_apdu_decoder.sv
// command decoder for odd binary read, record append and record read
`timescale 1ns/1ns
// Notes on behaviour
// - odd read p1-p2: selected, short id, full id
// - offset comes as tag 54 object
// - minimal length and value encoding recommended
// - no limit on odd read offset; here at most four value bytes
// - odd read allowed from offset zero
// - records numbered from one in creation order
// - append is 0C E2 with p1 00
// - append adds record after the last
// - append p2 top five bits short id
// - append answers 9000, 6A84 or 6700; here also 6E00, 6A86 or 6A82
// - record read is 0C B2, p1 record
// - read returns part, whole records, or both; here whole records only
// - missing record 6A83, otherwise 9000; here also 6E00, 6A86, 6A82 or 6700
// - read p2 low 100 one, 101 all
module file_record_apdu_decoder (
    input wire logic ref_clk, // system clock, 100 MHz
    input wire logic rstn, // async reset, active low
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte enables
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o // wishbone acknowledge
);
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_OPEN,
        PH_DONE
    } phase_type;

    phase_type phase_r;
    rec_cmd_pkg::cmd_hdr_type cmd_r; // staged header
    rec_cmd_pkg::cmd_hdr_type hdr_r; // header of open command
    logic [15:0] len_r; // staged lc
    logic [15:0] lc_r; // lc of open command
    logic [15:0] cnt_r; // data bytes received
    logic [15:0] sw_r;
    logic [4:0] rec_cnt_r;
    logic [4:0] cur_rec_r;
    logic [8:0] used_r;
    logic [8:0] rec_end_r [rec_cmd_pkg::REC_MAX];
    logic [7:0] rd_ptr_r;
    logic [8:0] left_r;
    logic [31:0] offset_r;
    rec_cmd_pkg::target_type target_r;

    logic req, wr, rd;
    logic start_p, end_p, byte_p, pop_p;
    logic is_bin, is_app, is_rrec;
    logic [15:0] app_sw, rrec_sw, bin_sw, final_sw;
    logic [4:0] eff_rec;
    logic [8:0] rd_start, rd_stop;
    logic mem_we;
    logic [7:0] mem_q;
    logic [31:0] tlv_off;
    logic tlv_ok;
    rec_cmd_pkg::target_type bin_tgt;

    // merge a write word into a register under the byte enables
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] val,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus strobes: one access per classic cycle, answered the next edge
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign start_p = wr && wb_adr_i == rec_cmd_pkg::ADDR_CTRL &&
        wb_sel_i[0] && wb_dat_i[rec_cmd_pkg::CTRL_START_BIT];
    assign end_p = wr && wb_adr_i == rec_cmd_pkg::ADDR_CTRL &&
        wb_sel_i[0] && wb_dat_i[rec_cmd_pkg::CTRL_END_BIT] &&
        phase_r == PH_OPEN && !start_p;
    assign byte_p = wr && wb_adr_i == rec_cmd_pkg::ADDR_DATA &&
        wb_sel_i[0] && phase_r == PH_OPEN;
    assign pop_p = rd && wb_adr_i == rec_cmd_pkg::ADDR_RESP &&
        left_r != 9'h000;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // staged header and lc, free to rewrite while a command is open
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmd_r <= rec_cmd_pkg::CMD_RESET;
            len_r <= 16'h0000;
        end else if (wr && wb_adr_i == rec_cmd_pkg::ADDR_CMD) begin
            cmd_r <= merge(cmd_r, wb_dat_i, wb_sel_i);
        end else if (wr && wb_adr_i == rec_cmd_pkg::ADDR_LEN) begin
            len_r <= 16'(merge({16'h0000, len_r}, wb_dat_i, wb_sel_i));
        end
    end

    // command phase and the latched copy used for checking
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= PH_IDLE;
            hdr_r <= rec_cmd_pkg::CMD_RESET;
            lc_r <= 16'h0000;
            cnt_r <= 16'h0000;
        end else if (start_p) begin
            phase_r <= PH_OPEN;
            hdr_r <= cmd_r;
            lc_r <= len_r;
            cnt_r <= 16'h0000;
        end else if (end_p) begin
            phase_r <= PH_DONE;
        end else if (byte_p && cnt_r != 16'hFFFF) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command recognition
    assign is_bin = hdr_r.ins == rec_cmd_pkg::INS_BIN_ODD;
    assign is_app = hdr_r.ins == rec_cmd_pkg::INS_APPEND;
    assign is_rrec = hdr_r.ins == rec_cmd_pkg::INS_READ_REC;
    assign bin_tgt = rec_cmd_pkg::decode_bin_target(hdr_r.p1, hdr_r.p2);

    // append checks depend only on latched header and file fill state,
    // so they stay steady while the record bytes stream in
    always_comb begin
        if (hdr_r.cla != rec_cmd_pkg::CLA_SM) begin
            app_sw = rec_cmd_pkg::SW_BAD_CLA;
        end else if (hdr_r.p1 != rec_cmd_pkg::P1_NONE ||
                     hdr_r.p2[2:0] != rec_cmd_pkg::P2_APPEND_LOW) begin
            app_sw = rec_cmd_pkg::SW_BAD_P1P2;
        end else if (!rec_cmd_pkg::sfi_hits(hdr_r.p2)) begin
            app_sw = rec_cmd_pkg::SW_NO_FILE;
        end else if (lc_r > rec_cmd_pkg::REC_MAX_LEN ||
                     lc_r == 16'h0000) begin
            app_sw = rec_cmd_pkg::SW_WRONG_LEN;
        end else if (rec_cnt_r == rec_cmd_pkg::REC_MAX_CNT ||
                     {7'h00, used_r} + lc_r > rec_cmd_pkg::FILE_BYTES) begin
            app_sw = rec_cmd_pkg::SW_NO_SPACE;
        end else begin
            app_sw = rec_cmd_pkg::SW_OK;
        end
    end

    // record read checks; p1 of zero means the current record
    assign eff_rec = (hdr_r.p1 == rec_cmd_pkg::P1_NONE) ?
        cur_rec_r : hdr_r.p1[4:0];
    always_comb begin
        if (hdr_r.cla != rec_cmd_pkg::CLA_SM) begin
            rrec_sw = rec_cmd_pkg::SW_BAD_CLA;
        end else if (hdr_r.p2[2:0] != rec_cmd_pkg::P2_READ_ONE &&
                     hdr_r.p2[2:0] != rec_cmd_pkg::P2_READ_ALL) begin
            rrec_sw = rec_cmd_pkg::SW_BAD_P1P2;
        end else if (!rec_cmd_pkg::sfi_hits(hdr_r.p2)) begin
            rrec_sw = rec_cmd_pkg::SW_NO_FILE;
        end else if (lc_r != 16'h0000) begin
            rrec_sw = rec_cmd_pkg::SW_WRONG_LEN;
        end else if (hdr_r.p1[7:5] != 3'b000 || eff_rec == 5'h00 ||
                     eff_rec > rec_cnt_r) begin
            rrec_sw = rec_cmd_pkg::SW_NO_RECORD;
        end else begin
            rrec_sw = rec_cmd_pkg::SW_OK;
        end
    end

    // odd binary read: the block decodes, file access lies elsewhere
    always_comb begin
        if (hdr_r.cla != rec_cmd_pkg::CLA_PLAIN &&
            hdr_r.cla != rec_cmd_pkg::CLA_SM) begin
            bin_sw = rec_cmd_pkg::SW_BAD_CLA;
        end else if (bin_tgt.kind == rec_cmd_pkg::TGT_INVALID) begin
            bin_sw = rec_cmd_pkg::SW_BAD_P1P2;
        end else if (lc_r == 16'h0000) begin
            bin_sw = rec_cmd_pkg::SW_WRONG_LEN;
        end else if (!tlv_ok) begin
            bin_sw = rec_cmd_pkg::SW_BAD_DATA;
        end else begin
            bin_sw = rec_cmd_pkg::SW_OK;
        end
    end

    // a data count that disagrees with lc fails every recognised command
    always_comb begin
        if (!is_bin && !is_app && !is_rrec) begin
            final_sw = rec_cmd_pkg::SW_BAD_INS;
        end else if (cnt_r != lc_r) begin
            final_sw = rec_cmd_pkg::SW_WRONG_LEN;
        end else if (is_app) begin
            final_sw = app_sw;
        end else if (is_rrec) begin
            final_sw = rrec_sw;
        end else begin
            final_sw = bin_sw;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // record bytes go past the fill mark; they only count once committed,
    // so a rejected append leaves the file as it was
    assign mem_we = byte_p && is_app && app_sw == rec_cmd_pkg::SW_OK &&
        cnt_r < lc_r;

    rec_mem u_mem (
        .ref_clk(ref_clk),
        .we(mem_we),
        .waddr(used_r[7:0] + cnt_r[7:0]),
        .wdata(wb_dat_i[7:0]),
        .raddr(rd_ptr_r),
        .rdata(mem_q)
    );

    offset_tlv_parser u_tlv (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clear(start_p),
        .byte_valid(byte_p && is_bin),
        .byte_data(wb_dat_i[7:0]),
        .offset(tlv_off),
        .ok(tlv_ok)
    );

    ////////////////////////////////////////////////////////////////////////
    // record table: end mark of each record, numbered from one
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rec_cnt_r <= 5'h00;
            used_r <= 9'h000;
            for (int i = 0; i < rec_cmd_pkg::REC_MAX; i++) begin
                rec_end_r[i] <= 9'h000;
            end
        end else if (end_p && is_app && final_sw == rec_cmd_pkg::SW_OK) begin
            rec_end_r[rec_cnt_r[3:0]] <= used_r + lc_r[8:0];
            used_r <= used_r + lc_r[8:0];
            rec_cnt_r <= rec_cnt_r + 5'h01;
        end
    end

    // current record: last appended, or last one a read returned
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cur_rec_r <= 5'h00;
        end else if (end_p && final_sw == rec_cmd_pkg::SW_OK) begin
            if (is_app) begin
                cur_rec_r <= rec_cnt_r + 5'h01;
            end else if (is_rrec) begin
                cur_rec_r <= (hdr_r.p2[2:0] == rec_cmd_pkg::P2_READ_ALL) ?
                    rec_cnt_r : eff_rec;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // response window: one record or from the record through the last
    assign rd_start = (eff_rec <= 5'h01) ? 9'h000 :
        rec_end_r[4'(eff_rec - 5'h02)];
    assign rd_stop = (hdr_r.p2[2:0] == rec_cmd_pkg::P2_READ_ALL) ? used_r :
        rec_end_r[4'(eff_rec - 5'h01)];

    // whole records are returned; software may stop popping early and
    // then holds only the leading part of the last one
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_ptr_r <= 8'h00;
            left_r <= 9'h000;
        end else if (start_p) begin
            left_r <= 9'h000;
        end else if (end_p && is_rrec && final_sw == rec_cmd_pkg::SW_OK) begin
            rd_ptr_r <= rd_start[7:0];
            left_r <= rd_stop - rd_start;
        end else if (pop_p) begin
            rd_ptr_r <= rd_ptr_r + 8'h01;
            left_r <= left_r - 9'h001;
        end
    end

    // answer and decoded odd-read target
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sw_r <= rec_cmd_pkg::SW_NONE;
            offset_r <= 32'h0000_0000;
            target_r <= '0;
        end else if (start_p) begin
            sw_r <= rec_cmd_pkg::SW_NONE;
        end else if (end_p) begin
            sw_r <= final_sw;
            if (is_bin && final_sw == rec_cmd_pkg::SW_OK) begin
                offset_r <= tlv_off;
                target_r <= bin_tgt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped and write-only addresses read as zero
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd) begin
            unique case (wb_adr_i)
                rec_cmd_pkg::ADDR_CMD: wb_dat_o <= cmd_r;
                rec_cmd_pkg::ADDR_LEN: wb_dat_o <= {16'h0000, len_r};
                rec_cmd_pkg::ADDR_STATUS: begin
                    wb_dat_o <= {16'h0000, sw_r};
                    wb_dat_o[rec_cmd_pkg::ST_OPEN_BIT] <= phase_r == PH_OPEN;
                    wb_dat_o[rec_cmd_pkg::ST_DONE_BIT] <= phase_r == PH_DONE;
                end
                rec_cmd_pkg::ADDR_RESP: begin
                    wb_dat_o <= {24'h00_0000, pop_p ? mem_q : 8'h00};
                end
                rec_cmd_pkg::ADDR_LEFT: wb_dat_o <= {23'h00_0000, left_r};
                rec_cmd_pkg::ADDR_OFFSET: wb_dat_o <= offset_r;
                rec_cmd_pkg::ADDR_TARGET: wb_dat_o <= {14'h0000, target_r};
                rec_cmd_pkg::ADDR_RECS: begin
                    wb_dat_o <= {19'h0_0000, cur_rec_r, 3'b000, rec_cnt_r};
                end
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// >>> logic/offset_tlv_parser.sv
// parser of the offset data object carried by the odd binary read
`timescale 1ns/1ns
module offset_tlv_parser (
    input wire logic ref_clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic clear, // restart at a new command
    input wire logic byte_valid, // one data byte this cycle
    input wire logic [7:0] byte_data, // the data byte
    output logic [31:0] offset, // offset value collected
    output logic ok // a complete well formed object seen
);
    typedef enum logic [2:0] {
        P_TAG,
        P_LEN,
        P_VAL,
        P_DONE,
        P_BAD
    } parse_state_type;

    parse_state_type state_r;
    logic [7:0] remain_r;

    ////////////////////////////////////////////////////////////////////////
    // tag, short-form length, then big-endian value bytes
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= P_TAG;
            remain_r <= 8'h00;
            offset <= 32'h0000_0000;
        end else if (clear) begin
            state_r <= P_TAG;
            remain_r <= 8'h00;
            offset <= 32'h0000_0000;
        end else if (byte_valid) begin
            unique case (state_r)
                P_TAG: begin
                    state_r <= (byte_data == rec_cmd_pkg::TAG_OFFSET) ?
                        P_LEN : P_BAD;
                end
                P_LEN: begin
                    // long-form lengths would never be minimal here
                    if (byte_data >= rec_cmd_pkg::LEN_LONG_FORM ||
                        byte_data > rec_cmd_pkg::OFF_MAX_BYTES) begin
                        state_r <= P_BAD;
                    end else if (byte_data == 8'h00) begin
                        state_r <= P_DONE;
                    end else begin
                        remain_r <= byte_data;
                        state_r <= P_VAL;
                    end
                end
                P_VAL: begin
                    // any value accepted, zero included, no window check
                    offset <= {offset[23:0], byte_data};
                    remain_r <= remain_r - 8'h01;
                    if (remain_r == 8'h01) begin
                        state_r <= P_DONE;
                    end
                end
                P_DONE: state_r <= P_BAD; // trailing bytes
                P_BAD: state_r <= P_BAD;
            endcase
        end
    end

    assign ok = (state_r == P_DONE);
endmodule

// >>> logic/rec_cmd_pkg.sv
// shared constants, types and decode helpers of the record command decoder
package rec_cmd_pkg;

    ////////////////////////////////////////////////////////////////////////
    // command header and offset object bytes
    localparam logic [7:0] CLA_PLAIN = 8'h00;
    localparam logic [7:0] CLA_SM = 8'h0C;
    localparam logic [7:0] INS_BIN_ODD = 8'hB1;
    localparam logic [7:0] INS_APPEND = 8'hE2;
    localparam logic [7:0] INS_READ_REC = 8'hB2;
    localparam logic [7:0] P1_NONE = 8'h00;
    localparam logic [7:0] TAG_OFFSET = 8'h54;
    localparam logic [7:0] LEN_LONG_FORM = 8'h80;
    localparam logic [7:0] OFF_MAX_BYTES = 8'h04;

    // low three bits of p2
    localparam logic [2:0] P2_APPEND_LOW = 3'b000;
    localparam logic [2:0] P2_READ_ONE = 3'b100;
    localparam logic [2:0] P2_READ_ALL = 3'b101;

    ////////////////////////////////////////////////////////////////////////
    // status words
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
    localparam logic [15:0] SW_BAD_DATA = 16'h6A80;
    localparam logic [15:0] SW_NO_FILE = 16'h6A82;
    localparam logic [15:0] SW_NO_RECORD = 16'h6A83;
    localparam logic [15:0] SW_NO_SPACE = 16'h6A84;
    localparam logic [15:0] SW_BAD_P1P2 = 16'h6A86;
    localparam logic [15:0] SW_BAD_INS = 16'h6D00;
    localparam logic [15:0] SW_BAD_CLA = 16'h6E00;
    localparam logic [15:0] SW_NONE = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // record file geometry
    localparam int MEM_AW = 8;
    localparam int MEM_DEPTH = 256;
    localparam int REC_MAX = 16;
    localparam logic [4:0] REC_MAX_CNT = 5'h10;
    localparam logic [15:0] REC_MAX_LEN = 16'h0080;
    localparam logic [15:0] FILE_BYTES = 16'h0100;
    localparam logic [4:0] FILE_SFI = 5'h01;
    localparam logic [4:0] SFI_CURRENT = 5'h00;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets and fields
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_LEN = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_DATA = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_RESP = 8'h14;
    localparam logic [7:0] ADDR_LEFT = 8'h18;
    localparam logic [7:0] ADDR_OFFSET = 8'h1C;
    localparam logic [7:0] ADDR_TARGET = 8'h20;
    localparam logic [7:0] ADDR_RECS = 8'h24;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_END_BIT = 1;
    localparam int ST_OPEN_BIT = 16;
    localparam int ST_DONE_BIT = 17;
    localparam int TGT_KIND_LSB = 16;
    localparam int RECS_CUR_LSB = 8;
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic [7:0] cla;
        logic [7:0] ins;
        logic [7:0] p1;
        logic [7:0] p2;
    } cmd_hdr_type;

    typedef enum logic [1:0] {
        TGT_SELECTED,
        TGT_SFI,
        TGT_FID,
        TGT_INVALID
    } tgt_kind_type;

    typedef struct packed {
        tgt_kind_type kind;
        logic [15:0] id;
    } target_type;

    // target file of the odd binary read from p1-p2
    function automatic target_type decode_bin_target(input logic [7:0] p1,
                                                     input logic [7:0] p2);
        target_type t;
        t.id = {p1, p2};
        if (p1 != P1_NONE) begin
            t.kind = TGT_FID;
        end else if (p2 == 8'h00) begin
            t.kind = TGT_SELECTED;
        end else if (p2[7:5] == 3'b000) begin
            t.kind = TGT_SFI;
        end else begin
            t.kind = TGT_INVALID;
        end
        return t;
    endfunction

    // short file reference in p2 names the record file or the current one
    function automatic logic sfi_hits(input logic [7:0] p2);
        return (p2[7:3] == SFI_CURRENT) || (p2[7:3] == FILE_SFI);
    endfunction

endpackage

// >>> logic/rec_mem.sv
// byte store of the linear record file, registered read port
`timescale 1ns/1ns
module rec_mem (
    input wire logic ref_clk, // system clock
    input wire logic we, // write strobe
    input wire logic [rec_cmd_pkg::MEM_AW-1:0] waddr, // write address
    input wire logic [7:0] wdata, // write byte
    input wire logic [rec_cmd_pkg::MEM_AW-1:0] raddr, // read address
    output logic [7:0] rdata // read byte, one cycle late
);
    logic [7:0] mem_r [rec_cmd_pkg::MEM_DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // no reset on the array: contents are only valid below the fill mark
    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    // read data registered so it maps onto block ram
    always_ff @(posedge ref_clk) begin
        rdata <= mem_r[raddr];
    end
endmodule

// >>> sim/rec_cmd_checker.sv
// bus-side assertions for the record command decoder
`timescale 1ns/1ns
module rec_cmd_checker (
    input wire logic ref_clk, // clock
    input wire logic rstn, // reset, active low
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write
    input wire logic [7:0] wb_adr_i, // address
    input wire logic [3:0] wb_sel_i, // byte enables
    input wire logic [31:0] wb_dat_i, // write data
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o // acknowledge
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!rstn);
logic tk;
logic rd_r;
logic [7:0] ra_r;
assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
// remember the read in flight so its answer can be judged by address
always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
        rd_r <= 1'b0;
        ra_r <= 8'h00;
    end else begin
        rd_r <= tk && !wb_we_i;
        ra_r <= wb_adr_i;
    end
end
ack_on_time_a: assert property (tk |=> wb_ack_o) else $error("late ack");
ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
ack_cause_a: assert property (wb_ack_o |-> $past(tk)) else $error("stray ack");
wo_reads_zero_a: assert property (wb_ack_o && rd_r && ra_r inside {8'h08,
    8'h0C} |-> wb_dat_o == 32'h0000_0000) else $error("wo read not 0");
unmapped_zero_a: assert property (wb_ack_o && rd_r && ra_r > 8'h24
    |-> wb_dat_o == 32'h0000_0000) else $error("hole read not 0");
status_word_a: assert property (wb_ack_o && rd_r &&
    ra_r == 8'h10 |-> wb_dat_o[15:0] inside {16'h0000, 16'h9000} ||
    wb_dat_o[15:8] inside {8'h67, 8'h6A, 8'h6D, 8'h6E}) else $error("bad sw");
rec_count_a: assert property (wb_ack_o && rd_r && ra_r == 8'h24 |->
    wb_dat_o[4:0] <= 5'h10 && wb_dat_o[12:8] <= wb_dat_o[4:0])
    else $error("bad record count");
left_bound_a: assert property (wb_ack_o && rd_r && ra_r == 8'h18 |->
    wb_dat_o[8:0] <= 9'h100) else $error("left too large");
endmodule
bind file_record_apdu_decoder rec_cmd_checker i_chk (.*);

// >>> sim/tb_top.sv
// top testbench for the record command decoder
`timescale 1ns/1ns
module tb_top;
logic ref_clk = 1'b0;
logic rstn = 1'b0;
logic cyc, stb, we, ack;
logic [7:0] adr;
logic [3:0] sel;
logic [31:0] wd, rdat;
int n_mismatch = 0;
int num_checks = 0;
int cyc_cnt = 0;
logic [39:0] all_bytes = 40'h10_1112_2021;
initial forever #5 ref_clk = ~ref_clk;
file_record_apdu_decoder i_file_record_apdu_decoder (.ref_clk(ref_clk),
    .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack));
term_model i_term_model (.ref_clk(ref_clk), .ack(ack), .dat_o(rdat),
    .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wd));
task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
task automatic chk(input string nm, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        n_mismatch++;
    end
endtask
task automatic cmd(input logic [31:0] h, input int n, input logic [31:0] d,
                   input logic [15:0] e);
    logic [15:0] sw;
    i_term_model.send(h, n, d, sw);
    chk("status word", {16'h0, e}, {16'h0, sw});
endtask
task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_term_model.xfer(1'b0, a, 32'h0000_0000, q);
    chk("register read", e, q);
endtask
// a hang is cut short well beyond the expected run length
always @(posedge ref_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
        n_mismatch++;
        final_report();
    end
end
initial begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(8'h24, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    cmd(32'h0CB2_010C, 0, 32'h0, 16'h6A83);
    cmd(32'h0CE2_0008, 3, 32'h1011_1200, 16'h9000);
    cmd(32'h0CE2_0008, 2, 32'h2021_0000, 16'h9000);
    rd(8'h24, 32'h0000_0202);
    cmd(32'h0CE2_0108, 1, 32'h0, 16'h6A86);
    cmd(32'h0CE2_0009, 1, 32'h0, 16'h6A86);
    cmd(32'h0CE2_0008, 129, 32'h0, 16'h6700);
    rd(8'h24, 32'h0000_0202);
    cmd(32'h0CB2_020C, 0, 32'h0, 16'h9000);
    rd(8'h18, 32'h0000_0002);
    rd(8'h14, 32'h0000_0020);
    rd(8'h14, 32'h0000_0021);
    cmd(32'h0CB2_010D, 0, 32'h0, 16'h9000);
    rd(8'h18, 32'h0000_0005);
    for (int i = 0; i < 5; i++) rd(8'h14, all_bytes[39-8*i -: 8]);
    cmd(32'h0CB2_030C, 0, 32'h0, 16'h6A83);
    cmd(32'h0CB2_0004, 0, 32'h0, 16'h9000);
    rd(8'h18, 32'h0000_0002);
    cmd(32'h00B1_0000, 4, 32'h5402_FFFF, 16'h9000);
    rd(8'h1C, 32'h0000_FFFF);
    rd(8'h20, 32'h0000_0000);
    cmd(32'h0CB1_0102, 3, 32'h5401_0100, 16'h9000);
    rd(8'h20, 32'h0002_0102);
    rd(8'h1C, 32'h0000_0001);
    cmd(32'h00B1_0005, 2, 32'h5400_0000, 16'h9000);
    rd(8'h1C, 32'h0000_0000);
    rd(8'h20, 32'h0001_0005);
    cmd(32'h00B1_0020, 3, 32'h5401_0100, 16'h6A86);
    cmd(32'h00B1_0000, 3, 32'h5301_0100, 16'h6A80);
    cmd(32'h0CE2_0008, 128, 32'h0, 16'h9000);
    cmd(32'h0CE2_0008, 128, 32'h0, 16'h6A84);
    rd(8'h10, 32'h0002_6A84);
    cmd(32'h00E2_0008, 1, 32'h0, 16'h6E00);
    cmd(32'h0CE2_0010, 1, 32'h0, 16'h6A82);
    cmd(32'h0CA0_0000, 0, 32'h0, 16'h6D00);
    cmd(32'h0CB2_010C, 1, 32'h0, 16'h6700);
    rd(8'h10, 32'h0002_6700);
    rd(8'h0C, 32'h0000_0000);
    rd(8'h24, 32'h0000_0303);
    final_report();
end
endmodule

// >>> sim/term_model.sv
// terminal model: builds commands and speaks classic wishbone
`timescale 1ns/1ns
module term_model (
    input wire logic ref_clk, // clock
    input wire logic ack, // slave acknowledge
    input wire logic [31:0] dat_o, // slave read data
    output logic cyc, // cycle
    output logic stb, // strobe
    output logic we, // write
    output logic [7:0] adr, // address
    output logic [3:0] sel, // byte enables, always all
    output logic [31:0] dat // write data
);
initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    dat = 32'h0000_0000;
end
// one single cycle; request held until ack is seen at an edge
task automatic xfer(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge ref_clk);
    while (ack !== 1'b1) @(posedge ref_clk);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
endtask
// whole command; first four data bytes from d, later ones a count
task automatic send(input logic [31:0] hdr, input int n,
                    input logic [31:0] d, output logic [15:0] sw);
    logic [31:0] q;
    xfer(1'b1, 8'h00, hdr, q);
    xfer(1'b1, 8'h04, n, q);
    xfer(1'b1, 8'h08, 32'h0000_0001, q);
    for (int i = 0; i < n; i++) begin
        xfer(1'b1, 8'h0C,
             {24'h0, i < 4 ? d[31-8*i -: 8] : i[7:0]}, q);
    end
    xfer(1'b1, 8'h08, 32'h0000_0002, q);
    xfer(1'b0, 8'h10, 32'h0000_0000, q);
    sw = q[15:0];
endtask
endmodule
